// File: inc/lpi_pkg.sv
// Constants shared by the pin interface of the low-power DDR device
package lpi_pkg;
  localparam int CA_W       = 10;
  localparam int LANE_W     = 8;
  localparam int LANES_X16  = 2;
  localparam int LANES_X32  = 4;
  localparam int CMD_W      = 2 * CA_W + 2;
  // Pair state {ck, ck_n} just after each differential edge
  localparam logic [1:0] CK_RISE = 2'b10;
  localparam logic [1:0] CK_FALL = 2'b01;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [1:0] PWR_NONE = 2'h0;
  localparam logic [1:0] PWR_ENTRY = 2'h1;
  localparam logic [1:0] PWR_EXIT  = 2'h2;
  typedef enum logic [1:0] {LPI_IDLE, LPI_WRITE, LPI_READ} lpi_dir_t;
endpackage

// File: rtl/lpi_pins.sv
// Device-side pin interface: clock edges, command capture, data, strobes and masks
`timescale 1ns/10ps
module lpi_pins #(
  parameter int LANES = lpi_pkg::LANES_X32
) (
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  // Pins to and from the controller
  input  wire logic                          ck_pin,
  input  wire logic                          ck_n_pin,
  input  wire logic                          cke_pin,
  input  wire logic                          cs_n_pin,
  input  wire logic [lpi_pkg::CA_W-1:0]      ca_pin,
  input  wire logic [LANES*lpi_pkg::LANE_W-1:0] dq_in,
  output logic      [LANES*lpi_pkg::LANE_W-1:0] dq_out,
  output logic                               dq_oe,
  input  wire logic [LANES-1:0]              dqs_in,
  input  wire logic [LANES-1:0]              dqs_n_in,
  output logic      [LANES-1:0]              dqs_out,
  output logic      [LANES-1:0]              dqs_n_out,
  output logic                               dqs_oe,
  input  wire logic [LANES-1:0]              dm_pin,
  // Core side: decoded command
  output logic                               cmd_valid,
  output logic      [lpi_pkg::CMD_W-1:0]     cmd_word,
  output logic      [1:0]                    pwr_event,
  output logic                               core_clk_en,
  // Core side: write beats
  output logic                               wr_valid,
  input  wire logic                          wr_ready,
  output logic      [LANES*lpi_pkg::LANE_W-1:0] wr_data,
  output logic      [LANES-1:0]              wr_lane_en,
  // Core side: read beats and direction
  input  wire logic                          rd_valid,
  output logic                               rd_ready,
  input  wire logic [LANES*lpi_pkg::LANE_W-1:0] rd_data,
  input  wire logic                          rd_enable,
  input  wire logic                          wr_enable
);
  localparam int DW = LANES * lpi_pkg::LANE_W;

  // Only the two documented widths have strobe and mask pins
  if (LANES != lpi_pkg::LANES_X16 && LANES != lpi_pkg::LANES_X32) begin : g_bad_lanes
    $error("LANES must be 2 or 4");
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Every pin passes two flops; stage one is read only by stage two
  // Trade-off: two cycles of latency on every pin buy immunity to metastability
  localparam int SW = 3 + lpi_pkg::CA_W + DW + 3 * LANES;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {ck_pin, ck_n_pin, cke_pin, ca_pin, dq_in, dqs_in, dqs_n_in, dm_pin};
      s2_q <= s1_q;
    end
  end
  logic                     ck_s;
  logic                     ck_n_s;
  logic                     cke_s;
  logic [lpi_pkg::CA_W-1:0] ca_s;
  logic [DW-1:0]            dq_s;
  logic [LANES-1:0]         dqs_s;
  logic [LANES-1:0]         dqs_n_s;
  logic [LANES-1:0]         dm_s;
  assign {ck_s, ck_n_s, cke_s, ca_s, dq_s, dqs_s, dqs_n_s, dm_s} = s2_q;

  // Chip select is active low, so it is synchronised with a reset of one
  logic cs_n1_q;
  logic cs_n2_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_n1_q <= 1'b1;
      cs_n2_q <= 1'b1;
    end else begin
      cs_n1_q <= cs_n_pin;
      cs_n2_q <= cs_n1_q;
    end
  end

  // ****************************************************************
  // Differential clock edge detection
  // ****************************************************************
  // Previous pair state; an edge needs both legs to cross together
  // Reset matches the parked pair (CK low), so release shows no false edge
  logic [1:0] ck_prev_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_prev_q <= lpi_pkg::CK_FALL;
    end else begin
      ck_prev_q <= {ck_s, ck_n_s};
    end
  end
  // Both edge decoders ask the same question of the pair history
  function automatic logic pair_cross(input logic [1:0] prev_st,
                                      input logic [1:0] cur_st,
                                      input logic [1:0] src_st,
                                      input logic [1:0] dst_st);
    return (prev_st == src_st) && (cur_st == dst_st);
  endfunction
  // A lone leg crossing (noise or skew) matches neither pattern
  logic ck_pos;
  logic ck_neg;
  assign ck_pos = pair_cross(ck_prev_q, {ck_s, ck_n_s},
                             lpi_pkg::CK_FALL, lpi_pkg::CK_RISE);
  assign ck_neg = pair_cross(ck_prev_q, {ck_s, ck_n_s},
                             lpi_pkg::CK_RISE, lpi_pkg::CK_FALL);

  // ****************************************************************
  // Command capture and power decode
  // ****************************************************************
  // Rising half plus CS and CKE at the positive edge
  // CS is kept active high so the command word reads as a select flag
  logic [lpi_pkg::CA_W-1:0] ca_rise_q;
  logic                     cs_q;
  logic                     cke_q;
  logic                     half_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ca_rise_q  <= '0;
      cs_q       <= 1'b0;
      cke_q      <= 1'b0;
      half_q     <= 1'b0;
    end else if (ck_pos) begin
      ca_rise_q  <= ca_s;
      cs_q       <= !cs_n2_q;
      cke_q      <= cke_s;
      half_q     <= 1'b1;
    end else if (ck_neg) begin
      half_q     <= 1'b0;
    end
  end

  // Command word issued once per clock, at the negative edge closing the cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_valid <= 1'b0;
      cmd_word  <= '0;
    end else begin
      cmd_valid <= ck_neg && half_q;
      if (ck_neg && half_q) begin
        cmd_word <= {cke_q, cs_q, ca_rise_q, ca_s};
      end
    end
  end

  // CKE transitions become power-mode entry and exit pulses
  // Judged against the level held since the last positive edge, not the raw pin
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_event   <= lpi_pkg::PWR_NONE;
      core_clk_en <= 1'b0;
    end else begin
      pwr_event <= lpi_pkg::PWR_NONE;
      if (ck_pos && cke_q && !cke_s) begin
        pwr_event <= lpi_pkg::PWR_ENTRY;
      end else if (ck_pos && !cke_q && cke_s) begin
        pwr_event <= lpi_pkg::PWR_EXIT;
      end
      if (ck_pos) begin
        core_clk_en <= cke_s;
      end
    end
  end

  // ****************************************************************
  // Write path: strobe edges, masks and skid buffer
  // ****************************************************************
  // Each present lane samples data and mask at both strobe edges
  logic [LANES-1:0] dqs_prev_q;
  logic [LANES-1:0] beat_lane;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqs_prev_q <= '0;
    end else begin
      dqs_prev_q <= dqs_s;
    end
  end
  // Lanes 2 and 3 are built only when LANES is four
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    // Differential crossing in either direction counts as a strobe edge
    assign beat_lane[l] = (dqs_s[l] != dqs_prev_q[l]) && (dqs_s[l] != dqs_n_s[l]);
  end

  logic          in_valid;
  logic [DW-1:0] in_data;
  logic [LANES-1:0] in_en;
  // A beat with every lane masked carries nothing and takes no buffer slot
  assign in_valid = wr_enable && core_clk_en && (|in_en);
  assign in_data  = dq_s;
  assign in_en    = beat_lane & ~dm_s;

  // Two-entry buffer keeps beats while the core stalls
  // Limitation: the pins cannot be stalled, so a third beat during a stall is lost
  logic [DW+LANES-1:0] buf_q [2];
  logic [1:0]          cnt_q;
  logic                rd_ptr_q;
  logic                wr_ptr_q;
  logic                buf_in_rdy;
  assign buf_in_rdy = (cnt_q != lpi_pkg::BUF_DEPTH);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (in_valid && buf_in_rdy) begin
        buf_q[wr_ptr_q] <= {in_en, in_data};
        wr_ptr_q        <= !wr_ptr_q;
      end
      if (wr_valid && wr_ready) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, in_valid && buf_in_rdy} - {1'b0, wr_valid && wr_ready};
    end
  end

  // Registered view of buffer head for the core
  // Head register copies the oldest entry, so the outputs come straight from flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid   <= 1'b0;
      wr_data    <= '0;
      wr_lane_en <= '0;
    end else begin
      wr_valid <= (cnt_q - {1'b0, wr_valid && wr_ready}) != 2'h0
                  || (in_valid && buf_in_rdy);
      if (!(wr_valid && !wr_ready)) begin
        if (cnt_q - {1'b0, wr_valid && wr_ready} != 2'h0) begin
          {wr_lane_en, wr_data} <= buf_q[rd_ptr_q ^ (wr_valid && wr_ready)];
        end else begin
          {wr_lane_en, wr_data} <= {in_en, in_data};
        end
      end
    end
  end

  // ****************************************************************
  // Read path: device drives data and edge-aligned strobes
  // ****************************************************************
  // A beat is launched at each CK edge; strobe toggles with the data
  // Limitation: CK must stay slow enough that each half period spans several cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_out    <= '0;
      dq_oe     <= 1'b0;
      dqs_out   <= '0;
      dqs_n_out <= '1;
      dqs_oe    <= 1'b0;
      rd_ready  <= 1'b0;
    end else begin
      dq_oe    <= rd_enable && core_clk_en;
      dqs_oe   <= rd_enable && core_clk_en;
      rd_ready <= rd_enable && core_clk_en && (ck_pos || ck_neg);
      if (rd_valid && rd_ready) begin
        dq_out    <= rd_data;
        dqs_out   <= ~dqs_out;
        dqs_n_out <= dqs_out;
      end else if (!rd_enable) begin
        dqs_out   <= '0;
        dqs_n_out <= '1;
      end
    end
  end
  // Mask pins and the CA bus have no output path at all

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_edge_excl: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(ck_pos && ck_neg)) else $error("both clock edges at once");
  a_cmd_single: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cmd_valid |=> !cmd_valid) else $error("command lasted two cycles");
  a_cmd_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cmd_valid |-> $past(ck_neg)) else $error("command without negative edge");
  a_cmd_fields: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cmd_valid |-> cmd_word[lpi_pkg::CMD_W-1] == $past(cke_q)) else $error("cke field wrong");
  a_pwr_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ck_pos && cke_q && !cke_s) |=> pwr_event == lpi_pkg::PWR_ENTRY)
    else $error("entry missed");
  a_clk_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ck_pos |=> core_clk_en == $past(cke_s)) else $error("clock enable not followed");
  a_drv_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !core_clk_en |=> !dq_oe && !dqs_oe) else $error("driver on while disabled");
  a_mask_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (in_valid && buf_in_rdy) |-> (in_en & dm_s) == '0) else $error("masked lane kept");
  a_buf_full: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cnt_q <= lpi_pkg::BUF_DEPTH) else $error("buffer overflow");
  // Decoded clock edges must issue command and power pulses with the right fields, and power pulses must trace back to an edge
  a_cmd_issue: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ck_neg && half_q) |=> cmd_valid) else $error("command not issued");
  a_cmd_cs: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cmd_valid |-> cmd_word[lpi_pkg::CMD_W-2] == $past(cs_q)) else $error("select field wrong");
  a_pwr_exit: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ck_pos && !cke_q && cke_s) |=> pwr_event == lpi_pkg::PWR_EXIT)
    else $error("exit missed");
  a_pwr_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pwr_event != lpi_pkg::PWR_NONE) |-> $past(ck_pos)) else $error("power event without edge");
  // Clock enable only moves at a positive edge and gates the write capture
  a_clk_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !$past(ck_pos) |-> $stable(core_clk_en)) else $error("clock enable moved off edge");
  a_wr_refuse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !core_clk_en |-> !in_valid) else $error("beat taken while disabled");
  a_wr_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (wr_valid && !wr_ready) |=> wr_valid && $stable(wr_data) && $stable(wr_lane_en))
    else $error("stalled beat changed");
  // Read drivers and strobes move together
  a_oe_pair: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dq_oe == dqs_oe) else $error("data and strobe enables differ");
  a_strobe_pair: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dqs_n_out == ~dqs_out) else $error("strobe legs not complementary");
  a_rd_align: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (rd_valid && rd_ready) |=> dq_out == $past(rd_data) && dqs_out == ~$past(dqs_out))
    else $error("read strobe not aligned with data");
  a_rdy_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd_ready |-> $past(ck_pos || ck_neg)) else $error("read beat taken without edge");
endmodule // lpi_pins

// File: tb/lpi_ctl_model.sv
// Behavioural memory controller that drives the device pins
`timescale 1ns/10ps
module lpi_ctl_model #(
  parameter int DW = 32,
  parameter int LN = 4
) (
  input  wire logic              sys_clk,
  output logic                   ck,
  output logic                   ck_n,
  output logic                   cke,
  output logic                   cs_n,
  output logic [lpi_pkg::CA_W-1:0] ca,
  output logic [DW-1:0]          dq,
  output logic [LN-1:0]          dqs,
  output logic [LN-1:0]          dqs_n,
  output logic [LN-1:0]          dm
);
  // ****************
  // Pin sequencing
  // ****************
  // Idle pins: clock parked low between commands, chip deselected
  initial begin
    {ck, cke, dqs, dm, dq, ca} = '0;
    {ck_n, cs_n} = 2'h3;
    dqs_n = '1;
  end

  // One half period of four system cycles: a 200 ns CK period
  task automatic half(input logic c);
    @(negedge sys_clk);
    ck   = c;
    ck_n = ~c;
    repeat (3) @(negedge sys_clk);
  endtask

  // One command in one CK cycle, CA halves on both edges
  task automatic cmd(input logic e, input logic s_n, input logic [9:0] r, input logic [9:0] f);
    @(negedge sys_clk);
    cke  = e;
    cs_n = s_n;
    ca   = r;
    half(1'b1);
    ca = f;
    half(1'b0);
    cs_n = 1'b1;
    ca   = ~f; // Hold over: stale CA must not look valid
  endtask

  // Write beat: data and mask first, strobe edge in mid-window
  task automatic wbeat(input logic [DW-1:0] d, input logic [LN-1:0] m);
    @(negedge sys_clk);
    dq = d;
    dm = m;
    repeat (2) @(negedge sys_clk);
    dqs   = ~dqs;
    dqs_n = ~dqs;
    repeat (4) @(negedge sys_clk);
    dq = ~d;
  endtask
endmodule // lpi_ctl_model

// File: tb/tb_top.sv
// Self-checking bench for the device pin interface
`timescale 1ns/10ps
module tb_top;
  localparam int LN = lpi_pkg::LANES_X32;
  localparam int DW = LN * lpi_pkg::LANE_W;
  logic                sys_clk, arst_n, ck, ck_n, cke, cs_n, dq_oe, dqs_oe;
  logic [9:0]          ca;
  logic [DW-1:0]       c_dq, dq_in, dq_out, wr_data, rd_data;
  logic [LN-1:0]       c_dqs, c_dqs_n, dqs_in, dqs_n_in, dqs_out, dqs_n_out, dm, wr_lane_en;
  logic                cmd_valid, core_clk_en, wr_valid, wr_ready, rd_valid, rd_ready;
  logic                rd_enable, wr_enable;
  logic [21:0]         cmd_word, last_cmd;
  logic [1:0]          pwr_event, last_pwr;
  int                  n_fail, n_compared, n_cmd, n_pwr, n_rdy, cyc;

  // Wire level of the shared pins from the device's enables; the controller drives them otherwise
  assign dq_in    = dq_oe ? dq_out : c_dq;
  assign dqs_in   = dqs_oe ? dqs_out : c_dqs;
  assign dqs_n_in = dqs_oe ? dqs_n_out : c_dqs_n;

  lpi_ctl_model #(.DW(DW), .LN(LN)) lpi_ctl_model_i (.sys_clk(sys_clk), .ck(ck), .ck_n(ck_n),
    .cke(cke), .cs_n(cs_n), .ca(ca), .dq(c_dq), .dqs(c_dqs), .dqs_n(c_dqs_n), .dm(dm));
  lpi_pins #(.LANES(LN)) lpi_pins_i (.sys_clk(sys_clk), .arst_n(arst_n), .ck_pin(ck),
    .ck_n_pin(ck_n), .cke_pin(cke), .cs_n_pin(cs_n), .ca_pin(ca), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_n_in(dqs_n_in), .dqs_out(dqs_out),
    .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe), .dm_pin(dm), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .pwr_event(pwr_event), .core_clk_en(core_clk_en),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_lane_en(wr_lane_en),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .rd_enable(rd_enable),
    .wr_enable(wr_enable));

  // ****************
  // Clock, monitors and reporting
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // One-cycle pulses are caught here so no task can miss them; also the hang limit
  always @(posedge sys_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_word;
    end
    if (pwr_event !== lpi_pkg::PWR_NONE) begin
      n_pwr++;
      last_pwr = pwr_event;
    end
    if (rd_ready === 1'b1) begin
      n_rdy++;
    end
    if (cyc == 6000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // CKE steps 1,0,1 then a deselected cycle: power events and the full command word
  task automatic t_cmd;
    logic [3:0] e = 4'b1101;
    logic [3:0] s = 4'b1000;
    logic [1:0] pw[4] = '{lpi_pkg::PWR_EXIT, lpi_pkg::PWR_ENTRY, lpi_pkg::PWR_EXIT,
                          lpi_pkg::PWR_NONE};
    int         nc, np;
    logic [9:0] r, f;
    for (int i = 0; i < 4; i++) begin
      nc = n_cmd;
      np = n_pwr;
      r  = 10'h2a5 ^ 10'(i);
      f  = 10'h15a ^ 10'(i);
      lpi_ctl_model_i.cmd(e[i], s[i], r, f);
      repeat (2) @(negedge sys_clk); // Command pulse is already up; the monitor counts it at the next edge
      chk(n_cmd == nc + 1, "one command per CK cycle");
      chk(last_cmd === {e[i], ~s[i], r, f}, "command word");
      chk(core_clk_en === e[i], "clock enable level");
      chk(pw[i] == lpi_pkg::PWR_NONE ? n_pwr == np
          : (n_pwr == np + 1 && last_pwr === pw[i]), "power event");
    end
    $display("test command done");
  endtask

  // Core stalls: buffer fills, fully masked beat dropped, beat to a full buffer dropped
  task automatic t_write;
    logic [DW-1:0] d[2] = '{32'h1122_3344, 32'ha5b6_c7d8};
    logic [LN-1:0] m[2] = '{4'hf, 4'ha};
    int            got = 0;
    wr_enable = 1'b1;
    lpi_ctl_model_i.wbeat(d[0], 4'h0);
    lpi_ctl_model_i.wbeat(32'hdead_0001, 4'hf);
    lpi_ctl_model_i.wbeat(d[1], 4'h5);
    lpi_ctl_model_i.wbeat(32'hbeef_0002, 4'h0);
    chk(wr_valid === 1'b1 && wr_data === d[0], "stalled beat held");
    wr_ready = 1'b1;
    // Look before each edge: the head stands until the edge that takes it
    repeat (12) begin
      if (wr_valid === 1'b1) begin
        chk(wr_data === d[got] && wr_lane_en === m[got], "write beat");
        got++;
      end
      @(negedge sys_clk);
    end
    chk(got == 2 && dq_oe === 1'b0, "beat count, bus left to controller");
    wr_enable = 1'b0;
    $display("test write done");
  endtask

  // One read beat per CK edge, strobe toggles with the data
  task automatic rd_edge(input logic lvl, input logic [DW-1:0] d);
    logic [LN-1:0] p;
    p       = dqs_out;
    rd_data = d;
    lpi_ctl_model_i.half(lvl);
    for (int i = 0; i < 8 && dq_out !== d; i++) @(negedge sys_clk);
    chk(dq_out === d && dq_oe === 1'b1, "read data");
    chk(dqs_out === ~p && dqs_n_out === ~dqs_out && dqs_oe === 1'b1, "read strobe");
  endtask

  task automatic t_read;
    int nr;
    nr        = n_rdy;
    rd_enable = 1'b1;
    rd_valid  = 1'b1;
    rd_edge(1'b1, 32'h0f1e_2d3c);
    rd_edge(1'b0, 32'hf0e1_d2c3);
    rd_enable = 1'b0;
    rd_valid  = 1'b0;
    for (int i = 0; i < 8 && dq_oe !== 1'b0; i++) @(negedge sys_clk);
    chk(dq_oe === 1'b0 && dqs_oe === 1'b0, "drivers released");
    chk(n_rdy == nr + 2, "one read beat taken per CK edge");
    $display("test read done");
  endtask

  // Main sequence: inputs change on falling edges
  initial begin
    {n_fail, n_compared, n_cmd, n_pwr, n_rdy, cyc} = '0;
    {arst_n, wr_ready, rd_valid, rd_enable, wr_enable} = '0;
    {last_cmd, last_pwr, rd_data} = '0;
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_cmd();
    t_write();
    t_read();
    end_sim();
  end
endmodule // tb_top
